/* core/led_ctrl_map.svh */
// constants of the led indicator controller: offsets, fields, resets, times
// Functional notes
// - sense each led wiring at every reset
// - polarity sensed once, never during operation
// - second led sourcing clears duplex select
// - second led sinking sets duplex select
// - no second led leaves duplex unspecified
// - reset: first shows link, second receive
// - first code bits 11-8, second 7-4
// - codes 1,2,3,7 show stretchable activity
// - code 4 link, code 5 duplex
// - codes C,D,E combine status, always stretched
// - codes 8-B on, off, fast, slow blink
// - bits 3-2 select stretch length
// - stretch lengths 40, 70, 140 ms
// - bit 1 enables pulse stretching
// - registers reached only through management port
`ifndef LED_CTRL_MAP_SVH
`define LED_CTRL_MAP_SVH

// ---------------------------------------------------------------------
// management addresses and reset values
// ---------------------------------------------------------------------
`define PHY_CTRL_ONE_ADDR 5'h00
`define LED_CTRL_ADDR 5'h14
`define DUPLEX_SEL_BIT 8
`define LED_CTRL_RESET 16'h3422

// ---------------------------------------------------------------------
// led control fields
// ---------------------------------------------------------------------
`define FIRST_FN_HI 11
`define FIRST_FN_LO 8
`define SECOND_FN_HI 7
`define SECOND_FN_LO 4
`define STRETCH_LEN_HI 3
`define STRETCH_LEN_LO 2
`define STRETCH_EN_BIT 1

// ---------------------------------------------------------------------
// function codes and stretch length codes
// ---------------------------------------------------------------------
`define FN_TX 4'h1
`define FN_RX 4'h2
`define FN_COL 4'h3
`define FN_LINK 4'h4
`define FN_DUPLEX 4'h5
`define FN_TXRX 4'h7
`define FN_ON 4'h8
`define FN_OFF 4'h9
`define FN_FAST 4'hA
`define FN_SLOW 4'hB
`define FN_LINK_RX 4'hC
`define FN_LINK_TXRX 4'hD
`define FN_DUPLEX_COL 4'hE
`define LEN_MEDIUM 2'h1
`define LEN_LONG 2'h2

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define CLK_HZ 100000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define NORMAL_STRETCH_MS 40
`define MEDIUM_STRETCH_MS 70
`define LONG_STRETCH_MS 140
`define FAST_BLINK_HALF_MS 100
`define SLOW_BLINK_HALF_MS 400
`define SENSE_CYC 3'h4

`endif

/* core/led_ctrl_pkg.sv */
// types of the led indicator controller
package led_ctrl_pkg;
  typedef logic [3:0] led_fn_t;
  typedef logic [15:0] mgmt_word_t;
  typedef enum logic [0:0] {SENSE, RUN} sense_state_t;
endpackage

/* core/led_stretch_if.sv */
// link between the controller and one pulse stretcher
`timescale 1ns/1ns
interface led_stretch_if #(parameter int CNT_W = 24);
  logic event_lvl;
  logic stretch;
  logic [CNT_W-1:0] hold_cyc;
  logic lit;
  modport ctrl (output event_lvl, output stretch, output hold_cyc,
                input lit);
  modport unit (input event_lvl, input stretch, input hold_cyc,
                output lit);
endinterface

/* core/led_stretch.sv */
// pulse stretcher: keeps an activity indication lit for a hold time
`timescale 1ns/1ns
module led_stretch #(
  parameter int CNT_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  led_stretch_if.unit s
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // ---------------------------------------------------------------
  // hold counter
  // ---------------------------------------------------------------
  // counter reloads while the event lasts, then runs down
  always_comb begin
    if (!s.stretch) begin
      cnt_nxt = '0;
    end else if (s.event_lvl) begin
      cnt_nxt = s.hold_cyc;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end else begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // lit while the event lasts, and while the hold runs when enabled
  assign s.lit = s.event_lvl | (s.stretch & (cnt_r != '0));
endmodule

/* core/led_ctrl.sv */
// led indicator controller: polarity sensing, function decode, drive
`timescale 1ns/1ns
`include "led_ctrl_map.svh"
module led_ctrl #(
  parameter int STRETCH_W = 24,
  parameter int BLINK_W = 26,
  parameter int NORMAL_STRETCH_CYC = `NORMAL_STRETCH_MS * `CYC_PER_MS,
  parameter int MEDIUM_STRETCH_CYC = `MEDIUM_STRETCH_MS * `CYC_PER_MS,
  parameter int LONG_STRETCH_CYC = `LONG_STRETCH_MS * `CYC_PER_MS,
  parameter int FAST_BLINK_CYC = `FAST_BLINK_HALF_MS * `CYC_PER_MS,
  parameter int SLOW_BLINK_CYC = `SLOW_BLINK_HALF_MS * `CYC_PER_MS
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [4:0] MGMT_ADDR_I,
  input wire logic MGMT_WR_I,
  input wire logic MGMT_RD_I,
  input wire logic [15:0] MGMT_WDATA_I,
  output logic [15:0] MGMT_RDATA_O,
  input wire logic LINK_UP_I,
  input wire logic TX_ACT_I,
  input wire logic RX_ACT_I,
  input wire logic COL_I,
  input wire logic FIRST_LED_PIN_I,
  output logic FIRST_LED_PIN_O,
  output logic FIRST_LED_PIN_OE_O,
  input wire logic SECOND_LED_PIN_I,
  output logic SECOND_LED_PIN_O,
  output logic SECOND_LED_PIN_OE_O,
  output logic PHY_DUPLEX_SELECT_O
);

  // ---------------------------------------------------------------
  // decode helpers, shared by both leds
  // ---------------------------------------------------------------
  // activity that feeds the stretcher for a given function code
  function automatic logic fn_event(led_ctrl_pkg::led_fn_t fn,
                                    logic tx, logic rx, logic col);
    logic ev;
    ev = 1'b0;
    case (fn)
      `FN_TX: ev = tx;
      `FN_RX: ev = rx;
      `FN_COL: ev = col;
      `FN_TXRX: ev = tx | rx;
      `FN_LINK_RX: ev = rx;
      `FN_LINK_TXRX: ev = tx | rx;
      `FN_DUPLEX_COL: ev = col;
      default: ev = 1'b0;
    endcase
    return ev;
  endfunction

  // combined codes stretch whatever the enable bit says
  function automatic logic fn_forced(led_ctrl_pkg::led_fn_t fn);
    return (fn == `FN_LINK_RX) || (fn == `FN_LINK_TXRX) ||
           (fn == `FN_DUPLEX_COL);
  endfunction

  // logical on/off state of an led; reserved codes stay dark
  function automatic logic fn_on(led_ctrl_pkg::led_fn_t fn, logic link,
                                 logic dup, logic act, logic fast,
                                 logic slow);
    logic on;
    on = 1'b0;
    case (fn)
      `FN_TX, `FN_RX, `FN_COL, `FN_TXRX: on = act;
      `FN_LINK: on = link;
      `FN_DUPLEX: on = dup;
      `FN_ON: on = 1'b1;
      `FN_OFF: on = 1'b0;
      `FN_FAST: on = fast;
      `FN_SLOW: on = slow;
      // status lit, activity shown by briefly inverting it
      `FN_LINK_RX, `FN_LINK_TXRX: on = link ^ act;
      `FN_DUPLEX_COL: on = dup ^ act;
      default: on = 1'b0;
    endcase
    return on;
  endfunction

  // a sinking led lights when the pin is pulled low
  function automatic logic pin_level(logic on, logic sink);
    return on ^ sink;
  endfunction

  // ---------------------------------------------------------------
  // pin input synchronisers
  // ---------------------------------------------------------------
  logic a_s1_r, a_s2_r, b_s1_r, b_s2_r;
  logic a_s1_nxt, a_s2_nxt, b_s1_nxt, b_s2_nxt;

  // pins are outside the clock domain, so two flops before any use
  always_comb begin
    a_s1_nxt = FIRST_LED_PIN_I;
    a_s2_nxt = a_s1_r;
    b_s1_nxt = SECOND_LED_PIN_I;
    b_s2_nxt = b_s1_r;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      a_s1_r <= 1'b0;
      a_s2_r <= 1'b0;
      b_s1_r <= 1'b0;
      b_s2_r <= 1'b0;
    end else begin
      a_s1_r <= a_s1_nxt;
      a_s2_r <= a_s2_nxt;
      b_s1_r <= b_s1_nxt;
      b_s2_r <= b_s2_nxt;
    end
  end

  // ---------------------------------------------------------------
  // polarity sensing after reset
  // ---------------------------------------------------------------
  led_ctrl_pkg::sense_state_t state_r, state_nxt;
  logic [2:0] sense_cnt_r, sense_cnt_nxt;
  logic a_sink_r, a_sink_nxt, b_sink_r, b_sink_nxt;
  logic sense_done;

  // pins float while sensing; an led tied to the supply pulls the
  // pin high, meaning the pin must sink current to light it
  assign sense_done = (state_r == led_ctrl_pkg::SENSE) &&
                      (sense_cnt_r == `SENSE_CYC - 3'h1);

  always_comb begin
    state_nxt = state_r;
    sense_cnt_nxt = sense_cnt_r;
    a_sink_nxt = a_sink_r;
    b_sink_nxt = b_sink_r;
    case (state_r)
      led_ctrl_pkg::SENSE: begin
        sense_cnt_nxt = sense_cnt_r + 3'h1;
        if (sense_done) begin
          a_sink_nxt = a_s2_r;
          b_sink_nxt = b_s2_r;
          state_nxt = led_ctrl_pkg::RUN;
        end
      end
      led_ctrl_pkg::RUN: begin
        state_nxt = led_ctrl_pkg::RUN; // no re-sensing until reset
      end
      default: state_nxt = led_ctrl_pkg::SENSE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r <= led_ctrl_pkg::SENSE; // every reset senses again
      sense_cnt_r <= 3'h0;
      a_sink_r <= 1'b0;
      b_sink_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sense_cnt_r <= sense_cnt_nxt;
      a_sink_r <= a_sink_nxt;
      b_sink_r <= b_sink_nxt;
    end
  end

  // ---------------------------------------------------------------
  // management registers
  // ---------------------------------------------------------------
  led_ctrl_pkg::mgmt_word_t led_ctrl_r, led_ctrl_nxt;
  led_ctrl_pkg::mgmt_word_t rdata_r, rdata_nxt;
  logic duplex_r, duplex_nxt;
  logic wr_led, wr_phy, rd_led, rd_phy;

  // only the management port reaches these registers
  assign wr_led = MGMT_WR_I && (MGMT_ADDR_I == `LED_CTRL_ADDR);
  assign wr_phy = MGMT_WR_I && (MGMT_ADDR_I == `PHY_CTRL_ONE_ADDR);
  assign rd_led = MGMT_RD_I && (MGMT_ADDR_I == `LED_CTRL_ADDR);
  assign rd_phy = MGMT_RD_I && (MGMT_ADDR_I == `PHY_CTRL_ONE_ADDR);

  // reserved bits are stored as written; software keeps them
  always_comb begin
    led_ctrl_nxt = wr_led ? MGMT_WDATA_I : led_ctrl_r;
    duplex_nxt = duplex_r;
    if (sense_done) begin
      // an unconnected second pin floats, so this default is whatever
      // level the pin happened to settle at
      duplex_nxt = b_s2_r; // sink sets, source clears
    end else if (wr_phy) begin
      duplex_nxt = MGMT_WDATA_I[`DUPLEX_SEL_BIT];
    end
    rdata_nxt = rdata_r;
    if (rd_led) begin
      rdata_nxt = led_ctrl_r;
    end else if (rd_phy) begin
      rdata_nxt = '0;
      rdata_nxt[`DUPLEX_SEL_BIT] = duplex_r;
    end else if (MGMT_RD_I) begin
      rdata_nxt = '0; // unmapped addresses read as zero
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      led_ctrl_r <= `LED_CTRL_RESET; // link on first, rx on second
      duplex_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      led_ctrl_r <= led_ctrl_nxt;
      duplex_r <= duplex_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // field extraction and stretch time select
  // ---------------------------------------------------------------
  led_ctrl_pkg::led_fn_t fn_a, fn_b;
  logic [1:0] len_sel;
  logic str_en;
  logic [STRETCH_W-1:0] hold_cyc;

  assign fn_a = led_ctrl_r[`FIRST_FN_HI:`FIRST_FN_LO];
  assign fn_b = led_ctrl_r[`SECOND_FN_HI:`SECOND_FN_LO];
  assign len_sel = led_ctrl_r[`STRETCH_LEN_HI:`STRETCH_LEN_LO];
  assign str_en = led_ctrl_r[`STRETCH_EN_BIT];

  // the reserved length code falls back to the normal time
  always_comb begin
    case (len_sel)
      `LEN_MEDIUM: hold_cyc = STRETCH_W'(MEDIUM_STRETCH_CYC);
      `LEN_LONG: hold_cyc = STRETCH_W'(LONG_STRETCH_CYC);
      default: hold_cyc = STRETCH_W'(NORMAL_STRETCH_CYC);
    endcase
  end

  // ---------------------------------------------------------------
  // pulse stretchers, one per led
  // ---------------------------------------------------------------
  led_stretch_if #(.CNT_W(STRETCH_W)) str_a ();
  led_stretch_if #(.CNT_W(STRETCH_W)) str_b ();

  assign str_a.event_lvl = fn_event(fn_a, TX_ACT_I, RX_ACT_I, COL_I);
  assign str_a.stretch = str_en | fn_forced(fn_a);
  assign str_a.hold_cyc = hold_cyc;
  assign str_b.event_lvl = fn_event(fn_b, TX_ACT_I, RX_ACT_I, COL_I);
  assign str_b.stretch = str_en | fn_forced(fn_b);
  assign str_b.hold_cyc = hold_cyc;

  led_stretch #(.CNT_W(STRETCH_W)) u_str_a (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .s(str_a.unit)
  );

  led_stretch #(.CNT_W(STRETCH_W)) u_str_b (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .s(str_b.unit)
  );

  // ---------------------------------------------------------------
  // blink generators
  // ---------------------------------------------------------------
  logic [BLINK_W-1:0] fast_cnt_r, fast_cnt_nxt, slow_cnt_r, slow_cnt_nxt;
  logic fast_ph_r, fast_ph_nxt, slow_ph_r, slow_ph_nxt;

  // free running, so both leds blink in step when set alike
  always_comb begin
    fast_cnt_nxt = fast_cnt_r + BLINK_W'(1);
    fast_ph_nxt = fast_ph_r;
    if (fast_cnt_r == BLINK_W'(FAST_BLINK_CYC - 1)) begin
      fast_cnt_nxt = '0;
      fast_ph_nxt = ~fast_ph_r;
    end
    slow_cnt_nxt = slow_cnt_r + BLINK_W'(1);
    slow_ph_nxt = slow_ph_r;
    if (slow_cnt_r == BLINK_W'(SLOW_BLINK_CYC - 1)) begin
      slow_cnt_nxt = '0;
      slow_ph_nxt = ~slow_ph_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      fast_cnt_r <= '0;
      slow_cnt_r <= '0;
      fast_ph_r <= 1'b0;
      slow_ph_r <= 1'b0;
    end else begin
      fast_cnt_r <= fast_cnt_nxt;
      slow_cnt_r <= slow_cnt_nxt;
      fast_ph_r <= fast_ph_nxt;
      slow_ph_r <= slow_ph_nxt;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  logic a_out_r, a_out_nxt, b_out_r, b_out_nxt;
  logic a_oe_r, b_oe_r, oe_nxt;
  logic dup_r, dup_nxt;

  // pins released while sensing; the first driven cycle already needs
  // the new polarity, so the next sink values are used here
  always_comb begin
    oe_nxt = (state_nxt == led_ctrl_pkg::RUN);
    a_out_nxt = pin_level(fn_on(fn_a, LINK_UP_I, duplex_r, str_a.lit,
                                fast_ph_r, slow_ph_r), a_sink_nxt);
    b_out_nxt = pin_level(fn_on(fn_b, LINK_UP_I, duplex_r, str_b.lit,
                                fast_ph_r, slow_ph_r), b_sink_nxt);
    dup_nxt = duplex_nxt;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      a_out_r <= 1'b0;
      b_out_r <= 1'b0;
      a_oe_r <= 1'b0;
      b_oe_r <= 1'b0;
      dup_r <= 1'b0;
    end else begin
      a_out_r <= a_out_nxt;
      b_out_r <= b_out_nxt;
      a_oe_r <= oe_nxt;
      b_oe_r <= oe_nxt;
      dup_r <= dup_nxt;
    end
  end

  assign FIRST_LED_PIN_O = a_out_r;
  assign FIRST_LED_PIN_OE_O = a_oe_r;
  assign SECOND_LED_PIN_O = b_out_r;
  assign SECOND_LED_PIN_OE_O = b_oe_r;
  assign PHY_DUPLEX_SELECT_O = dup_r;
  assign MGMT_RDATA_O = rdata_r;
endmodule

/* verification/led_ctrl_sva.sv */
// port checker for the led indicator controller
`timescale 1ns/1ns
`include "led_ctrl_map.svh"
module led_ctrl_sva (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [4:0] MGMT_ADDR_I,
  input wire logic MGMT_WR_I,
  input wire logic MGMT_RD_I,
  input wire logic [15:0] MGMT_WDATA_I,
  input wire logic [15:0] MGMT_RDATA_O,
  input wire logic LINK_UP_I,
  input wire logic RX_ACT_I,
  input wire logic FIRST_LED_PIN_I,
  input wire logic FIRST_LED_PIN_O,
  input wire logic FIRST_LED_PIN_OE_O,
  input wire logic SECOND_LED_PIN_I,
  input wire logic SECOND_LED_PIN_O,
  input wire logic SECOND_LED_PIN_OE_O,
  input wire logic PHY_DUPLEX_SELECT_O
);
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic sns1_r;
  logic sns1_nxt;
  logic sns2_r;
  logic sns2_nxt;
  logic [3:0] fn1;
  logic [3:0] fn2;
  // shadow control word; undriven pin level equals the off level
  always_comb begin
    ctl_nxt = ctl_r;
    if (MGMT_WR_I && MGMT_ADDR_I == `LED_CTRL_ADDR) begin
      ctl_nxt = MGMT_WDATA_I;
    end
    sns1_nxt = FIRST_LED_PIN_OE_O ? sns1_r : FIRST_LED_PIN_I;
    sns2_nxt = SECOND_LED_PIN_OE_O ? sns2_r : SECOND_LED_PIN_I;
  end
  // registers of the shadow state
  always_ff @(posedge CLK_I) begin
    ctl_r <= RST_N_I ? ctl_nxt : `LED_CTRL_RESET;
    sns1_r <= sns1_nxt;
    sns2_r <= sns2_nxt;
  end
  assign fn1 = ctl_r[11:8];
  assign fn2 = ctl_r[7:4];
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_drive_after_sense: assert property (
    $rose(RST_N_I) |-> !FIRST_LED_PIN_OE_O ##1 !SECOND_LED_PIN_OE_O
    ##[1:4] FIRST_LED_PIN_OE_O) else $error("led drive not enabled");
  a_duplex_sensed: assert property (
    $rose(SECOND_LED_PIN_OE_O) |-> PHY_DUPLEX_SELECT_O == sns2_r)
    else $error("duplex select not from wiring");
  a_unmapped_zero: assert property (
    MGMT_RD_I && !(MGMT_ADDR_I inside {5'h00, `LED_CTRL_ADDR})
    |=> MGMT_RDATA_O == 16'h0000) else $error("unmapped read not zero");
  a_ctl_read_back: assert property (
    MGMT_RD_I && MGMT_ADDR_I == `LED_CTRL_ADDR
    |=> MGMT_RDATA_O == $past(ctl_r)) else $error("control read wrong");
  a_rdata_holds: assert property (
    !MGMT_RD_I |=> $stable(MGMT_RDATA_O)) else $error("read data moved");
  a_fixed_on: assert property (
    FIRST_LED_PIN_OE_O && fn1 == `FN_ON |=> FIRST_LED_PIN_O == !sns1_r)
    else $error("on code not lit");
  a_fixed_off: assert property (
    SECOND_LED_PIN_OE_O && fn2 == `FN_OFF |=> SECOND_LED_PIN_O == sns2_r)
    else $error("off code lit");
  a_link_follow: assert property (
    FIRST_LED_PIN_OE_O && fn1 == `FN_LINK
    |=> FIRST_LED_PIN_O == ($past(LINK_UP_I) ^ sns1_r))
    else $error("link display wrong");
  a_rx_direct: assert property (
    SECOND_LED_PIN_OE_O && fn2 == `FN_RX && !ctl_r[`STRETCH_EN_BIT]
    |=> SECOND_LED_PIN_O == ($past(RX_ACT_I) ^ sns2_r))
    else $error("unstretched receive display wrong");
endmodule
bind led_ctrl led_ctrl_sva u_sva (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .MGMT_ADDR_I(MGMT_ADDR_I), .MGMT_WR_I(MGMT_WR_I), .MGMT_RD_I(MGMT_RD_I),
  .MGMT_WDATA_I(MGMT_WDATA_I), .MGMT_RDATA_O(MGMT_RDATA_O),
  .LINK_UP_I(LINK_UP_I), .RX_ACT_I(RX_ACT_I),
  .FIRST_LED_PIN_I(FIRST_LED_PIN_I), .FIRST_LED_PIN_O(FIRST_LED_PIN_O),
  .FIRST_LED_PIN_OE_O(FIRST_LED_PIN_OE_O),
  .SECOND_LED_PIN_I(SECOND_LED_PIN_I), .SECOND_LED_PIN_O(SECOND_LED_PIN_O),
  .SECOND_LED_PIN_OE_O(SECOND_LED_PIN_OE_O),
  .PHY_DUPLEX_SELECT_O(PHY_DUPLEX_SELECT_O));

/* verification/led_pair_model.sv */
// two indicator leds with the pull resistors of their wiring
`timescale 1ns/1ns
module led_pair_model (
  input wire logic sink1_i,
  input wire logic sink2_i,
  input wire logic drv1_i,
  input wire logic oe1_i,
  input wire logic drv2_i,
  input wire logic oe2_i,
  output logic lvl1_o,
  output logic lvl2_o,
  output logic lit1_o,
  output logic lit2_o
);
  // undriven pin rests at its pull: up for a sinking led, down otherwise
  assign lvl1_o = oe1_i ? drv1_i : sink1_i;
  assign lvl2_o = oe2_i ? drv2_i : sink2_i;
  // a sinking led glows with the pin low, a sourcing one with it high
  assign lit1_o = oe1_i && (drv1_i != sink1_i);
  assign lit2_o = oe2_i && (drv2_i != sink2_i);
endmodule

/* verification/led_ctrl_tb_top.sv */
// self-checking bench for the led indicator controller
`timescale 1ns/1ns
`include "led_ctrl_map.svh"
module led_ctrl_tb_top;
  localparam int NRM = 20;
  localparam int MED = 35;
  localparam int LNG = 70;
  localparam int FST = 8;
  localparam int SLW = 32;
  logic clk, rst_n, wr, rd, link, tx, rx, col, dup;
  logic p1i, p1o, p1oe, p2i, p2o, p2oe, sink1, sink2, lit1, lit2;
  logic [4:0] addr;
  logic [15:0] wdata, rdata;
  logic [2:0] act [4] = '{3'b100, 3'b010, 3'b001, 3'b010};
  logic [3:0] acode [4] = '{4'h1, 4'h2, 4'h3, 4'h7};
  logic [3:0] ccode [3] = '{4'hC, 4'hD, 4'hE};
  logic [3:0] rsv [3] = '{4'h0, 4'h6, 4'hF};
  int hlen [4] = '{NRM, MED, LNG, NRM};
  int n_mismatch, compares, n;

  led_ctrl #(.NORMAL_STRETCH_CYC(NRM), .MEDIUM_STRETCH_CYC(MED),
    .LONG_STRETCH_CYC(LNG), .FAST_BLINK_CYC(FST), .SLOW_BLINK_CYC(SLW)
  ) dut (.CLK_I(clk), .RST_N_I(rst_n), .MGMT_ADDR_I(addr),
    .MGMT_WR_I(wr), .MGMT_RD_I(rd), .MGMT_WDATA_I(wdata),
    .MGMT_RDATA_O(rdata), .LINK_UP_I(link), .TX_ACT_I(tx),
    .RX_ACT_I(rx), .COL_I(col), .FIRST_LED_PIN_I(p1i),
    .FIRST_LED_PIN_O(p1o), .FIRST_LED_PIN_OE_O(p1oe),
    .SECOND_LED_PIN_I(p2i), .SECOND_LED_PIN_O(p2o),
    .SECOND_LED_PIN_OE_O(p2oe), .PHY_DUPLEX_SELECT_O(dup));
  led_pair_model leds (.sink1_i(sink1), .sink2_i(sink2), .drv1_i(p1o),
    .oe1_i(p1oe), .drv2_i(p2o), .oe2_i(p2oe), .lvl1_o(p1i),
    .lvl2_o(p2i), .lit1_o(lit1), .lit2_o(lit2));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // inputs always move 1 ns after a rising edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts may land a cycle or two off the nominal figure
  task automatic near(input int k, input int e);
    chk((k >= e - 2 && k <= e + 2) ? e[15:0] : k[15:0], e[15:0]);
  endtask
  // idle cycle after each strobe so it never rises in the same step
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    chk(rdata, e);
    step(1);
  endtask
  // one-cycle activity pulse, then the cycles the led stays lit
  task automatic pulse(input logic [2:0] a, input logic two);
    {tx, rx, col} = a;
    step(1);
    {tx, rx, col} = 3'b000;
    step(1);
    n = 0;
    while (n < 400 && (two ? lit2 : lit1)) begin
      step(1);
      n++;
    end
  endtask
  // length of the first full half period of the first led, after the partial one
  task automatic half();
    logic v;
    for (int h = 0; h < 2; h++) begin
      v = lit1;
      n = 0;
      while (n < 200 && lit1 == v) begin
        step(1);
        n++;
      end
    end
  endtask
  task automatic reset_dut();
    rst_n = 1'b0;
    step(5);
    rst_n = 1'b1;
    n = 0;
    while (n < 20 && !(p1oe && p2oe)) begin
      step(1);
      n++;
    end
    if (n == 20) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic results();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and scenarios
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    {addr, wr, rd, wdata, link, tx, rx, col} = '0;
    {n_mismatch, compares} = '0;
    sink1 = 1'b0;
    sink2 = 1'b1;
    reset_dut();
    chk(dup, 1'b1);
    rd_chk(5'h00, 16'h0100);
    rd_chk(`LED_CTRL_ADDR, 16'h3422);
    rd_chk(5'h05, 16'h0000);
    link = 1'b1;
    step(2);
    chk(lit1, 1'b1);
    pulse(3'b010, 1'b1);
    near(n, NRM);
    link = 1'b0;
    wr_reg(`LED_CTRL_ADDR, 16'h3550);
    chk({lit1, lit2}, 2'b11);
    wr_reg(5'h00, 16'h0000);
    chk({dup, lit1}, 2'b00);
    wr_reg(`LED_CTRL_ADDR, 16'h3890);
    chk({lit1, lit2}, 2'b10);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`LED_CTRL_ADDR, {4'h3, rsv[i], rsv[i % 2], 4'h0});
      chk({lit1, lit2}, 2'b00);
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(`LED_CTRL_ADDR, {8'h30, acode[i], 4'h0});
      {tx, rx, col} = act[i];
      step(2);
      chk(lit2, 1'b1);
      {tx, rx, col} = 3'b000;
      step(2);
      chk(lit2, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(`LED_CTRL_ADDR, {8'h30, 4'h2, i[1:0], 2'b10});
      pulse(3'b010, 1'b1);
      near(n, hlen[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(`LED_CTRL_ADDR, {4'h3, ccode[i], 8'h00});
      // code C reacts to receive only, D to either, E to collision
      pulse(i == 0 ? 3'b010 : (i == 1 ? 3'b100 : 3'b001), 1'b0);
      near(n, NRM);
    end
    wr_reg(`LED_CTRL_ADDR, 16'h3A00);
    half();
    near(n, FST);
    wr_reg(`LED_CTRL_ADDR, 16'h3B00);
    half();
    near(n, SLW);
    sink1 = 1'b1;
    sink2 = 1'b0;
    link = 1'b1;
    reset_dut();
    step(2);
    chk({dup, lit1}, 2'b01);
    rd_chk(5'h00, 16'h0000);
    sink2 = 1'b1;
    // second led driven high: a re-sensing design would see the pin high
    wr_reg(`LED_CTRL_ADDR, 16'h3480);
    step(6);
    chk({dup, lit2}, 2'b00);
    results();
  end
endmodule
